// ---- logic/reset_boot_loader.sv ----
// Reset sequencer and serial boot-mode loader of the processor.
// Assumes reset pins and the mode bit come from outside and are synchronised here.
// Operation
// (RL1) Serial interface and mode clock run at system clock divided by 256.
// (RL2) System asserts power_good only after 100 ms of stable supplies and clock.
// (RL3) Stream reading starts right when power_good asserts.
// (RL4) System drives cold_reset_n low for power-on and cold resets.
// (RL5) cold_reset_n is already low when power_good asserts.
// (RL6) cold_reset_n held 65536 cycles after power_good, released after stream read.
// (RL7) System releases cold_reset_n and sys_reset_n synchronously to the clock.
// (RL8) sys_reset_n held 64 cycles after cold_reset_n release.
// (RL9) After mode bits load, PLLs lock and core clock becomes stable.
// (RL10) sys_reset_n asserted synchronously for a warm reset.
// (RL11) power_good low at least 64 reference clocks before a cold reset.
// (RL12) Power-on or cold reset ends by taking the Reset exception.
// (RL13) Warm reset holds sys_reset_n low at least 64 cycles.
// (RL14) Warm reset skips the stream, keeps clocks, takes Soft Reset exception.
// (RL15) Any reset resets state machines and starts at the reset vector.
// (RL16) Internal state survives a warm reset.
// (RL17) Mode clock output held high while power_good is low.
// (RL18) First mode clock rising edge 256 cycles after power_good asserts.
// (RL19) Source presents bit 0 at power_good, next bits after each rising edge.
// (RL20) Exactly 256 bits are sampled from the serial input.
// (RL21) Source supplies zeros for reserved bits.
// (RL22) Captured bits stay stable until the next power-on or cold load.
`timescale 1ns/1ps
module reset_boot_loader
  import reset_boot_pkg::*;
(
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_arst_n,
  input  wire logic                     i_power_good,
  input  wire logic                     i_cold_reset_n,
  input  wire logic                     i_sys_reset_n,
  input  wire logic                     i_boot_mode_serial_in,
  output logic                          o_boot_mode_serial_clock,
  output logic [255:0]                  o_boot_mode,
  output logic                          o_boot_mode_valid,
  output logic                          o_core_clock_stable,
  output logic                          o_core_reset,
  output logic                          o_start_pulse,
  output reset_boot_pkg::reset_exc_t    o_start_exception
);
  import reset_boot_pkg::*;

  // ==========================================================
  // Three-flop input synchronisers
  logic [2:0] pg_sync_reg;
  logic [2:0] cold_sync_reg;
  logic [2:0] sys_sync_reg;
  logic [2:0] din_sync_reg;
  logic       pg_reg;
  logic       cold_n_reg;
  logic       sys_n_reg;
  logic       din_reg;

  // Shift pins through three stages
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pg_sync_reg   <= 3'h0;
      cold_sync_reg <= 3'h0;
      sys_sync_reg  <= 3'h0;
      din_sync_reg  <= 3'h0;
    end else begin
      pg_sync_reg   <= {pg_sync_reg[1:0], i_power_good};
      cold_sync_reg <= {cold_sync_reg[1:0], i_cold_reset_n};
      sys_sync_reg  <= {sys_sync_reg[1:0], i_sys_reset_n};
      din_sync_reg  <= {din_sync_reg[1:0], i_boot_mode_serial_in};
    end
  end

  // Accept a level once stages two and three agree
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pg_reg     <= 1'b0;
      cold_n_reg <= 1'b0;
      sys_n_reg  <= 1'b0;
      din_reg    <= 1'b0;
    end else begin
      if (pg_sync_reg[1] == pg_sync_reg[2]) pg_reg <= pg_sync_reg[2];
      if (cold_sync_reg[1] == cold_sync_reg[2]) cold_n_reg <= cold_sync_reg[2];
      if (sys_sync_reg[1] == sys_sync_reg[2]) sys_n_reg <= sys_sync_reg[2];
      if (din_sync_reg[1] == din_sync_reg[2]) din_reg <= din_sync_reg[2];
    end
  end

  // ==========================================================
  // Sequencer
  seq_state_t state_reg;
  logic [7:0] div_reg;          // Position within one mode clock period
  logic [8:0] bit_cnt_reg;      // Bits sampled so far
  logic [6:0] lock_cnt_reg;
  logic       pg_prev_reg;
  logic       sys_prev_reg;
  logic       cold_done_reg;    // Last reset was power-on or cold
  logic       pg_rise;
  logic       sample;
  logic       div_step;         // Divider advances this cycle
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  boot_bit_t  fifo_out;
  boot_bit_t  fifo_in;

  assign pg_rise = pg_reg && !pg_prev_reg;
  // Sample at each mode clock rising edge, bit 0 at the first
  assign sample  = (state_reg == ST_LOAD) && (div_reg == 8'hFF) && fifo_in_ready; // RL20
  // The last count of a period waits for room in the FIFO
  assign div_step = (div_reg != 8'hFF) || fifo_in_ready;
  assign fifo_in = '{index: bit_cnt_reg[7:0], value: din_reg};

  // Edge history
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pg_prev_reg  <= 1'b0;
      sys_prev_reg <= 1'b0;
    end else begin
      pg_prev_reg  <= pg_reg;
      sys_prev_reg <= sys_n_reg;
    end
  end

  // State transitions
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= ST_OFF;
    end else if (!pg_reg) begin
      state_reg <= ST_OFF;                                   // RL17
    end else begin
      unique case (state_reg)
        ST_OFF:  if (pg_rise) state_reg <= ST_LOAD;          // RL3
        ST_LOAD: if (bit_cnt_reg == 9'(MODE_BITS) && !fifo_out_valid) state_reg <= ST_LOCK;
        ST_LOCK: if (lock_cnt_reg == 7'(PLL_LOCK_CYCLES)) state_reg <= ST_HOLD; // RL9
        ST_HOLD: if (cold_n_reg && sys_n_reg) state_reg <= ST_RUN;
        ST_RUN:  if (!cold_n_reg) state_reg <= ST_HOLD;
      endcase
    end
  end

  // Mode clock divider and bit counter, restarted on power_good
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_reg     <= 8'h00;
      bit_cnt_reg <= 9'h000;
    end else if (state_reg != ST_LOAD) begin
      div_reg     <= 8'h00;                                  // RL18
      bit_cnt_reg <= 9'h000;
    end else if (bit_cnt_reg != 9'(MODE_BITS)) begin
      if (div_step) begin
        div_reg <= div_reg + 8'h01;                          // RL1
      end
      if (sample) bit_cnt_reg <= bit_cnt_reg + 9'h001;
    end
  end

  // Mode clock: high when idle and for the first half period, low for the
  // second half, so each rise lands on the sample that ends a period
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_boot_mode_serial_clock <= 1'b1;
    end else if (state_reg != ST_LOAD || bit_cnt_reg == 9'(MODE_BITS)) begin
      o_boot_mode_serial_clock <= 1'b1;                      // RL17
    end else begin
      o_boot_mode_serial_clock <= (div_step ? div_reg + 8'h01 : div_reg) < 8'(MODE_HALF); // RL18
    end
  end

  boot_bit_fifo #(
    .WIDTH ($bits(boot_bit_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_arst_n    (i_arst_n),
    .i_flush     (pg_rise),
    .i_in_valid  (sample),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (1'b1),
    .o_out_data  (fifo_out)
  );

  // Mode register: written only during a load
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_boot_mode <= BOOT_MODE_RESET;
    end else if (fifo_out_valid) begin
      o_boot_mode[fifo_out.index] <= fifo_out.value;         // RL22
    end
  end

  // Load complete flag, cleared when a new load starts
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_boot_mode_valid <= 1'b0;
    end else if (pg_rise) begin
      o_boot_mode_valid <= 1'b0;
    end else if (state_reg == ST_LOAD && bit_cnt_reg == 9'(MODE_BITS) && !fifo_out_valid) begin
      o_boot_mode_valid <= 1'b1;                             // RL22
    end
  end

  // PLL lock timer and stable core clock
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lock_cnt_reg        <= 7'h00;
      o_core_clock_stable <= 1'b0;
    end else if (state_reg == ST_LOCK) begin
      lock_cnt_reg <= lock_cnt_reg + 7'h01;
      if (lock_cnt_reg == 7'(PLL_LOCK_CYCLES)) o_core_clock_stable <= 1'b1; // RL9
    end else if (state_reg == ST_OFF) begin
      lock_cnt_reg        <= 7'h00;
      o_core_clock_stable <= 1'b0;                           // RL14
    end
  end

  // Core reset and start exception
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_core_reset      <= 1'b1;
      o_start_pulse     <= 1'b0;
      o_start_exception <= EXC_NONE;
      cold_done_reg     <= 1'b1;
    end else begin
      o_start_pulse <= 1'b0;
      if (state_reg != ST_RUN || !sys_n_reg) begin
        o_core_reset <= 1'b1;                                // RL15
      end
      if (state_reg != ST_RUN) begin
        cold_done_reg <= 1'b1;                               // RL12
      end
      if (state_reg == ST_RUN && sys_n_reg && !sys_prev_reg) begin
        o_core_reset      <= 1'b0;                           // RL15
        o_start_pulse     <= 1'b1;
        o_start_exception <= cold_done_reg ? EXC_RESET : EXC_SOFT; // RL12 RL14
        cold_done_reg     <= 1'b0;                           // RL16
      end else if (state_reg == ST_RUN && sys_n_reg && o_core_reset) begin
        o_core_reset      <= 1'b0;
        o_start_pulse     <= 1'b1;
        o_start_exception <= cold_done_reg ? EXC_RESET : EXC_SOFT;
        cold_done_reg     <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  AST_CLK_HIGH_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RL17
    (state_reg == ST_OFF) |=> o_boot_mode_serial_clock) else $error("mode clock low while idle");

  AST_FIRST_EDGE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RL18
    $rose(state_reg == ST_LOAD) |-> o_boot_mode_serial_clock [*8]) else $error("mode clock not high after start");

  AST_FIRST_RISE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RL18
    $rose(state_reg == ST_LOAD) |-> ##256 $rose(o_boot_mode_serial_clock)) else $error("mode clock rise misplaced");

  AST_LOAD_START: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RL3
    (pg_rise && state_reg == ST_OFF) |=> (state_reg == ST_LOAD)) else $error("load did not start");

  AST_BIT_LIMIT: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RL20
    bit_cnt_reg <= 9'(MODE_BITS)) else $error("too many bits sampled");

  AST_MODE_STABLE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RL22
    (o_boot_mode_valid && !pg_rise) |=> $stable(o_boot_mode)) else $error("boot mode changed");

  AST_RESET_EXC: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RL12
    (state_reg == ST_HOLD && cold_n_reg && sys_n_reg) |-> ##[1:3] o_start_pulse) else $error("no start");

  AST_HOLD_RESET: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RL15
    (state_reg != ST_RUN) |=> o_core_reset) else $error("core left reset early");

  AST_LOCK_AFTER_LOAD: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n) // RL9
    $rose(o_core_clock_stable) |-> o_boot_mode_valid) else $error("clock stable before load");

endmodule // reset_boot_loader

// ---- logic/reset_boot_pkg.sv ----
// Package for the reset sequencer and boot-mode loader.
// Assumes a single system clock at 10 MHz.
package reset_boot_pkg;

  // ==========================================================
  // Timing
  localparam int          SYS_CLK_HZ        = 10_000_000;
  localparam int          MODE_DIV          = 256;          // Mode clock = sys clock / 256
  localparam int          MODE_HALF         = MODE_DIV / 2;
  localparam int          MODE_BITS         = 256;          // Boot-mode stream length
  localparam int          PLL_LOCK_CYCLES   = 64;           // Modelled lock time
  localparam int          FIFO_DEPTH        = 8;

  // ==========================================================
  // Reset values
  localparam logic [255:0] BOOT_MODE_RESET  = 256'h0;

  // ==========================================================
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_OFF     = 5'h01,
    ST_LOAD    = 5'h02,
    ST_LOCK    = 5'h04,
    ST_HOLD    = 5'h08,
    ST_RUN     = 5'h10
  } seq_state_t;

  // Exception that starts execution after a reset
  typedef enum logic [1:0] {
    EXC_NONE   = 2'h0,
    EXC_RESET  = 2'h1,
    EXC_SOFT   = 2'h2
  } reset_exc_t;

  // One sampled boot bit with its index
  typedef struct packed {
    logic [7:0] index;
    logic       value;
  } boot_bit_t;

endpackage

// ---- logic/boot_bit_fifo.sv ----
// FIFO that buffers sampled boot-mode bits on their way to the mode register.
// Assumes the same clock and reset as the sequencer.
`timescale 1ns/1ps
module boot_bit_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // ==========================================================
  // Handshakes
  assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_reg[rd_ptr_reg];

  // Storage
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (i_flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  AST_FIFO_NO_OVERFLOW: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    count_reg <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule // boot_bit_fifo

// ---- verification/boot_rom_model.sv ----
// Behavioural boot-mode ROM that feeds the serial mode stream.
// Assumes power_good and the mode clock come straight from the pins.
`timescale 1ns/1ps
module boot_rom_model #(
  parameter logic [255:0] PATTERN = 256'h0
) (
  input  wire logic i_sys_clk,
  input  wire logic i_power_good,
  input  wire logic i_mode_clock,
  output logic      o_serial
);
  logic [8:0] idx_reg   = 9'h000;
  logic       clk_q_reg = 1'b1;
  logic       junk_reg  = 1'b0;
  // ==========================================================
  // Bit pointer: bit 0 at power_good, next bit after each rise
  always_ff @(posedge i_sys_clk) begin
    clk_q_reg <= i_mode_clock;
    junk_reg  <= ~junk_reg;
    if (!i_power_good) begin
      idx_reg <= 9'h000;
    end else if (i_mode_clock && !clk_q_reg && !idx_reg[8]) begin
      idx_reg <= idx_reg + 9'h001;
    end
  end
  // Outside a frame the line toggles so stale data never looks valid
  assign o_serial = (i_power_good && !idx_reg[8]) ? PATTERN[idx_reg[7:0]] : junk_reg;
endmodule // boot_rom_model

// ---- verification/tb_reset_and_boot_mode_loader.sv ----
// Self-checking bench for the reset sequencer, boot loader and bit FIFO.
// Assumes the package and both design modules are compiled first.
`timescale 1ns/1ps
module tb_reset_and_boot_mode_loader;
  import reset_boot_pkg::*;
  // Bit 0 is reserved and held at zero
  localparam logic [255:0] PATTERN =
    256'h0123456789ABCDEFFEDCBA98765432105A5AC3C3F00F0FF01248EDB79669A55E;
  logic         clk = 1'b0;
  logic         arst_n, power_good, cold_reset_n, sys_reset_n;
  logic         serial_in, mode_clk, mode_valid, clk_stable, core_reset, start_pulse;
  logic [255:0] boot_mode;
  reset_exc_t   start_exc;
  int           error_cnt = 0;
  int           cmp_count = 0;

  // ==========================================================
  // Clock, 100 ns period
  initial forever #50 clk = ~clk;

  reset_boot_loader reset_boot_loader_i (
    .i_sys_clk(clk), .i_arst_n(arst_n), .i_power_good(power_good),
    .i_cold_reset_n(cold_reset_n), .i_sys_reset_n(sys_reset_n),
    .i_boot_mode_serial_in(serial_in), .o_boot_mode_serial_clock(mode_clk),
    .o_boot_mode(boot_mode), .o_boot_mode_valid(mode_valid),
    .o_core_clock_stable(clk_stable), .o_core_reset(core_reset),
    .o_start_pulse(start_pulse), .o_start_exception(start_exc));
  boot_rom_model #(.PATTERN(PATTERN)) boot_rom_model_i (
    .i_sys_clk(clk), .i_power_good(power_good), .i_mode_clock(mode_clk), .o_serial(serial_in));

  // ==========================================================
  // Compare, finish and bounded waits
  task check(input string what, input logic [255:0] seen, input logic [255:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task timed_out;
    error_cnt++;
    $display("wrong value wait expected done seen timeout");
    wrap_up();
  endtask
  function automatic logic flag(input int w);
    return (w == 0) ? mode_valid : (w == 1) ? clk_stable : start_pulse;
  endfunction
  task wait_for(input int w, input int bound);
    int n;
    n = 0;
    while (flag(w) !== 1'b1) begin
      if (n == bound) timed_out();
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // Cycles until the mode clock is seen low and then high again
  task wait_rise(output int n);
    logic low_seen;
    low_seen = 1'b0;
    n = 0;
    forever begin
      if (n == 2000) timed_out();
      @(posedge clk);
      #1;
      n++;
      if (mode_clk === 1'b0) low_seen = 1'b1;
      else if (low_seen && mode_clk === 1'b1) break;
    end
  endtask
  task check_start(input reset_exc_t exc);
    wait_for(2, 20);
    check("start exception", 256'(start_exc), 256'(exc));
    check("core reset at start", 256'(core_reset), 256'h0);
    @(posedge clk);
    #1;
    check("start pulse one cycle", 256'(start_pulse), 256'h0);
  endtask

  // ==========================================================
  // Scenarios
  task test_idle;
    check("idle mode clock", 256'(mode_clk), 256'h1);
    check("idle boot mode", boot_mode, 256'h0);
    check("idle valid", 256'(mode_valid), 256'h0);
    check("idle core reset", 256'(core_reset), 256'h1);
    $display("test idle done");
  endtask
  task test_power_on;
    int n;
    @(posedge clk);
    power_good <= 1'b1;
    wait_rise(n);
    check("first mode clock rise", 256'(n >= 256 && n <= 262), 256'h1);
    wait_rise(n);
    check("mode clock period", 256'(n), 256'h100);
    $display("test power on done");
  endtask
  // Second rise has just sampled bit 1; one cycle later the buffer has written it
  task test_first_bits;
    @(posedge clk);
    #1;
    check("first two bits", boot_mode, 256'(PATTERN[1:0]));
    check("valid during load", 256'(mode_valid), 256'h0);
    check("clock unstable during load", 256'(clk_stable), 256'h0);
    check("core reset during load", 256'(core_reset), 256'h1);
    $display("test first bits done");
  endtask
  task test_boot_start;
    wait_for(0, 70000);
    check("boot mode loaded", boot_mode, PATTERN);
    check("clock not stable at load end", 256'(clk_stable), 256'h0);
    wait_for(1, 80);
    @(posedge clk);
    cold_reset_n <= 1'b1;
    repeat (64) @(posedge clk);
    #1;
    check("core held by sys reset", 256'(core_reset), 256'h1);
    @(posedge clk);
    sys_reset_n <= 1'b1;
    check_start(EXC_RESET);
    $display("test boot start done");
  endtask
  task test_warm;
    @(posedge clk);
    sys_reset_n <= 1'b0;
    repeat (64) @(posedge clk);
    #1;
    check("warm core reset", 256'(core_reset), 256'h1);
    check("warm clock stable", 256'(clk_stable), 256'h1);
    check("warm mode clock idle", 256'(mode_clk), 256'h1);
    check("warm boot mode kept", boot_mode, PATTERN);
    @(posedge clk);
    sys_reset_n <= 1'b1;
    check_start(EXC_SOFT);
    $display("test warm done");
  endtask
  task test_cold;
    int n;
    @(posedge clk);
    cold_reset_n <= 1'b0;
    sys_reset_n  <= 1'b0;
    @(posedge clk);
    power_good <= 1'b0;
    repeat (64) @(posedge clk);
    #1;
    check("cold mode clock idle", 256'(mode_clk), 256'h1);
    check("cold clock unstable", 256'(clk_stable), 256'h0);
    check("cold core reset", 256'(core_reset), 256'h1);
    check("cold boot mode kept", boot_mode, PATTERN);
    @(posedge clk);
    power_good <= 1'b1;
    wait_rise(n);
    check("reload first rise", 256'(n >= 256 && n <= 262), 256'h1);
    $display("test cold done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    arst_n       = 1'b0;
    power_good   = 1'b0;
    cold_reset_n = 1'b0;
    sys_reset_n  = 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    test_idle();
    test_power_on();
    test_first_bits();
    test_boot_start();
    test_warm();
    test_cold();
    wrap_up();
  end
endmodule // tb_reset_and_boot_mode_loader
